// ===== hw/uhi_irq_status.sv
// host-mode interrupt enable/status registers and the level interrupt request
// assumes processor port inputs synchronous to clk; suspend and frame setup come from other sections
`timescale 1ns/10ps
`include "uhi_map.svh"
module uhi_irq_status (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // processor port, two-step address then data access
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic a0,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    // usb line levels
    input wire logic dPlus,
    input wire logic dMinus,
    // from control and frame setup registers
    input wire logic suspendMode,
    input wire logic sofEnable,
    input wire logic [`UHI_FT_W-1:0] frameLoad,
    // transfer channels a and b
    input wire logic chanDoneA,
    input wire logic chanDoneB,
    input wire logic [7:0] chanEventA,
    input wire logic [7:0] chanEventB,
    output logic [7:0] pktStatusA,
    output logic [7:0] pktStatusB,
    // interrupt and power
    output logic irq_request_out,
    output logic frameExpire,
    output logic txPowerDown,
    output logic ramSuspend,
    output logic clockGateOff
);
    uhi_pkg::uhi_byte_t addrPtr_ff;
    uhi_pkg::uhi_byte_t enable_ff;
    uhi_pkg::uhi_byte_t addrSlot_ff;
    uhi_pkg::uhi_byte_t flags_ff;
    uhi_pkg::uhi_byte_t nxt_flags;
    uhi_pkg::uhi_byte_t setVec;
    uhi_pkg::uhi_byte_t clrVec;
    uhi_pkg::uhi_byte_t liveFlags;
    uhi_pkg::uhi_byte_t readValue;
    uhi_pkg::uhi_line_t lineState_ff;
    uhi_pkg::uhi_line_t nxt_lineState;
    logic wrPrev_ff;
    logic rdPrev_ff;
    logic wrStart;
    logic rdStart;
    logic dataWrite;
    logic statusWrite;
    logic enableWrite;
    logic lineSe0;
    logic lineChange;
    logic noDevice;
    logic resumeSeen;
    logic [1:0] chanDone;
    logic [7:0] chanEvent [2];
    logic [7:0] pktStatus_ff [2];

    // strobe edges; a long strobe acts once
    // history resets high like an idle strobe, so a strobe held low through reset counts as an edge when reset ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPrev_ff <= 1'b1;
            rdPrev_ff <= 1'b1;
        end else begin
            wrPrev_ff <= wrN;
            rdPrev_ff <= rdN;
        end
    end

    assign wrStart = wrPrev_ff && !wrN && !csN;
    assign rdStart = rdPrev_ff && !rdN && !csN;
    assign dataWrite = wrStart && a0;
    assign statusWrite = dataWrite && (addrPtr_ff == `UHI_REG_STATUS);
    assign enableWrite = dataWrite && (addrPtr_ff == `UHI_REG_ENABLE);

    // address phase: a write with a0 low loads the pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addrPtr_ff <= `UHI_REG_RESET;
        end else if (wrStart && !a0) begin
            addrPtr_ff <= dataIn;
        end
    end

    // enable mask; reserved bits never store
    // a reserved bit kept here could raise a request from a flag with no source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= `UHI_REG_RESET;
        end else if (enableWrite) begin
            enable_ff <= dataIn & `UHI_ENABLE_MASK;
        end
    end

    // slot kept for slave address; host firmware is expected to leave it alone
    // plain storage: nothing in host mode reads it back into the logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addrSlot_ff <= `UHI_REG_RESET;
        end else if (dataWrite && (addrPtr_ff == `UHI_REG_ADDR_SLOT)) begin
            addrSlot_ff <= dataIn;
        end
    end

    // attach tracking: SE0 means no device, anything else means attached
    assign lineSe0 = !dPlus && !dMinus;
    always_comb begin
        nxt_lineState = lineState_ff;
        unique case (lineState_ff)
            uhi_pkg::LN_DETACHED: if (!lineSe0) nxt_lineState = uhi_pkg::LN_ATTACHED;
            uhi_pkg::LN_ATTACHED: if (lineSe0) nxt_lineState = uhi_pkg::LN_DETACHED;
        endcase
    end

    // reset state matches an idle SE0 bus, so no false attach follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineState_ff <= uhi_pkg::LN_DETACHED;
        end else begin
            lineState_ff <= nxt_lineState;
        end
    end

    // a change lasts one cycle; bit 5 holds it for software
    assign lineChange = (nxt_lineState != lineState_ff);
    assign noDevice = (lineState_ff == uhi_pkg::LN_DETACHED);
    // resume seen as a K state (D- high, D+ low) while suspended
    // limitation: a K state shorter than one clk period can be missed
    assign resumeSeen = suspendMode && dMinus && !dPlus;

    // frame timer stops while suspended since internal clocks are off
    // a stopped timer tracks frameLoad, so a new period applies at the next start
    uhi_frame_timer u_frame_timer (
        .clk(clk),
        .rst_n(rst_n),
        .run(sofEnable && !suspendMode),
        .loadValue(frameLoad),
        .expire(frameExpire)
    );

    // packet status per channel, loaded by its done event
    // the event byte is logged as given; decoding it is the channel logic's job
    assign chanDone = {chanDoneB, chanDoneA};
    assign chanEvent[0] = chanEventA;
    assign chanEvent[1] = chanEventB;
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pktStatus_ff[ch] <= `UHI_REG_RESET;
            end else if (chanDone[ch]) begin
                pktStatus_ff[ch] <= chanEvent[ch];
            end
        end
    end
    assign pktStatusA = pktStatus_ff[0];
    assign pktStatusB = pktStatus_ff[1];

    // flag sets ignore the enables; bit 6 stores only the resume event
    always_comb begin
        setVec = '0;
        setVec[`UHI_BIT_DONE_A] = chanDone[0];
        setVec[`UHI_BIT_DONE_B] = chanDone[1];
        setVec[`UHI_BIT_SOF] = frameExpire;
        setVec[`UHI_BIT_INSREM] = lineChange;
        setVec[`UHI_BIT_DETRES] = resumeSeen;
        clrVec = statusWrite ? dataIn : 8'h00;
        // bits 3 and 2 have no source, and the mask holds them at zero anyway
        // set is ORed after the clear so a same-cycle event survives
        nxt_flags = ((flags_ff & ~clrVec) | setVec) & `UHI_FLAG_MASK;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= `UHI_REG_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // bit 6 shows resume flag in suspend, presence level otherwise; bit 7 is live D+
    always_comb begin
        liveFlags = flags_ff;
        liveFlags[`UHI_BIT_DETRES] = suspendMode ? flags_ff[`UHI_BIT_DETRES] : noDevice;
        liveFlags[`UHI_BIT_DPLUS] = dPlus;
    end

    // level request: holds while any enabled flag stays uncleared
    // combinational, so a clearing write drops the request one cycle later
    assign irq_request_out = |(liveFlags & enable_ff & `UHI_ENABLE_MASK);

    // read mux; other offsets belong to other sections and read zero here
    // the pointer never steps, so each data access needs its own address phase
    always_comb begin
        readValue = 8'h00;
        if (!a0) begin
            readValue = addrPtr_ff;
        end else if (addrPtr_ff == `UHI_REG_ENABLE) begin
            readValue = enable_ff;
        end else if (addrPtr_ff == `UHI_REG_ADDR_SLOT) begin
            readValue = addrSlot_ff;
        end else if (addrPtr_ff == `UHI_REG_STATUS) begin
            readValue = liveFlags;
        end
    end

    // read data captured at strobe start so it stays stable for the cycle
    // reading has no side effect: only a write of ones clears a flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= 8'h00;
        end else if (rdStart) begin
            dataOut <= readValue;
        end
    end
    assign dataOe = !csN && !rdN;

    // suspend shuts transmitter, ram and clocks
    // these only mirror the control bit; the gating itself sits in other sections
    assign txPowerDown = suspendMode;
    assign ramSuspend = suspendMode;
    assign clockGateOff = suspendMode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // flags follow their events whatever the enables say
    a_flag_ignores_mask: assert property (chanDoneA && !enable_ff[0] |=> flags_ff[0])
        else $error("done flag not set while its enable is off");
    a_done_b_flag: assert property (chanDoneB && !enable_ff[1] |=> flags_ff[1])
        else $error("channel b done flag not set");
    a_frame_flag: assert property (frameExpire |=> flags_ff[4])
        else $error("frame expiry did not set its flag");
    a_attach_flag: assert property (lineChange |=> flags_ff[5])
        else $error("line change did not set bit 5");
    a_pkt_update: assert property (chanDoneB |=> pktStatusB == $past(chanEventB))
        else $error("packet status not updated on done");
    a_pkt_update_a: assert property (chanDoneA |=> pktStatusA == $past(chanEventA))
        else $error("channel a packet status not updated");
    a_no_resume_awake: assert property (!suspendMode && !flags_ff[6] |=> !flags_ff[6])
        else $error("resume flag set outside suspend");

    // software clears by writing ones; a same-cycle event still wins
    a_write_clear: assert property (statusWrite && dataIn[0] && !chanDoneA |=> !flags_ff[0])
        else $error("write of one did not clear flag");
    a_clear_done_b: assert property (statusWrite && dataIn[1] && !chanDoneB |=> !flags_ff[1])
        else $error("write of one did not clear channel b flag");
    a_zero_keeps: assert property (statusWrite && !dataIn[0] && flags_ff[0] |=> flags_ff[0])
        else $error("write of zero cleared a flag");
    a_set_wins: assert property (statusWrite && dataIn[1] && chanDoneB |=> flags_ff[1])
        else $error("clear beat a same-cycle event");
    a_reserved_zero: assert property (enable_ff[7] == 1'b0 && enable_ff[3:2] == 2'b00
        && flags_ff[3:2] == 2'b00)
        else $error("reserved bit holds a one");

    // request gating and level behaviour
    a_irq_needs_enable: assert property (enable_ff == 8'h00 |-> !irq_request_out)
        else $error("request raised with every enable off");
    a_done_a_irq: assert property (chanDoneA && enable_ff[0] && !enableWrite |=> irq_request_out)
        else $error("enabled channel a done did not raise request");
    a_irq_on_enable: assert property (chanDoneB && enable_ff[1] && !enableWrite |=> irq_request_out)
        else $error("enabled done flag did not raise request");
    a_irq_level_hold: assert property (irq_request_out && !statusWrite && !enableWrite && !lineChange
        ##1 $stable(suspendMode) |-> irq_request_out)
        else $error("request dropped without a clear");
    a_detect_enable: assert property (!suspendMode && noDevice && enable_ff[6] |-> irq_request_out)
        else $error("detect enable did not gate presence");
    a_resume_enable: assert property (suspendMode && enable_ff[6] && flags_ff[6] |-> irq_request_out)
        else $error("resume enable did not gate the resume flag");
    a_insrem_gate: assert property (lineChange && enable_ff[5] && !enableWrite |=> irq_request_out)
        else $error("insert/remove not routed to request");
    a_frame_gate: assert property (flags_ff[4] && enable_ff[4] |-> irq_request_out)
        else $error("frame flag not routed to request");

    // status bits as software reads them, plus enable storage and suspend quiet
    a_dplus_read: assert property (rdStart && a0 && addrPtr_ff == `UHI_REG_STATUS
        |=> dataOut[7] == $past(dPlus))
        else $error("status bit 7 is not the D+ level");
    a_status_reserved: assert property (rdStart && a0 && addrPtr_ff == `UHI_REG_STATUS
        |=> dataOut[3:2] == 2'b00)
        else $error("reserved status bits read as one");
    a_resume_flag: assert property (resumeSeen ##1 suspendMode |-> liveFlags[6])
        else $error("resume not shown in bit 6");
    a_present_bit: assert property (!lineSe0 ##1 !suspendMode |-> !liveFlags[6])
        else $error("bit 6 shows no device while attached");
    a_absent_bit: assert property (lineSe0 ##1 !suspendMode |-> liveFlags[6])
        else $error("bit 6 shows a device on an SE0 bus");
    a_enable_store: assert property (enableWrite |=> enable_ff == ($past(dataIn) & `UHI_ENABLE_MASK))
        else $error("enable mask did not store the written bits");
    a_suspend_quiet: assert property (suspendMode |=> !frameExpire)
        else $error("frame timer ran during suspend");

    // main scenarios worth seeing at least once
    c_done_irq: cover property (chanDoneA && enable_ff[0] ##1 irq_request_out);
    c_attach: cover property (lineChange && !lineSe0);
    c_frame_tick: cover property (frameExpire ##1 flags_ff[4]);
    c_clear_race: cover property (statusWrite && dataIn[0] && chanDoneA);
    c_resume_irq: cover property (resumeSeen && enable_ff[6] ##1 irq_request_out);
endmodule

// ===== hw/uhi_map.svh
// register offsets, bit positions, reset values and timing counts for the host irq status logic
// assumes inclusion by bare name from every design file of this block
//
// What this block does
// - status flags set regardless of enable bits
// - enabled set flag asserts the request output
// - request output is a level until cleared
// - enable bit 6 follows suspend: resume/detect
// - enable bit 5 gates insert/remove flag
// - frame timer expiry sets status bit 4
// - channel done sets flag, updates packet status
// - writing one to status bit clears it
// - status bit 7 shows live D+ level
// - bit 6 is resume flag or presence
// - SE0/idle transition sets status bit 5
// - channel B mirrors channel A behaviour
// - suspend powers down transceiver, ram, clocks
// - frame timer counts down at 12 MHz
`ifndef UHI_MAP_SVH
`define UHI_MAP_SVH

// register offsets on the processor port
`define UHI_REG_ENABLE 8'h06
`define UHI_REG_ADDR_SLOT 8'h07
`define UHI_REG_STATUS 8'h0d

// bit positions shared by enable and status
`define UHI_BIT_DONE_A 0
`define UHI_BIT_DONE_B 1
`define UHI_BIT_SOF 4
`define UHI_BIT_INSREM 5
`define UHI_BIT_DETRES 6
`define UHI_BIT_DPLUS 7

// implemented bits and reset values
`define UHI_ENABLE_MASK 8'h73
`define UHI_FLAG_MASK 8'h73
`define UHI_REG_RESET 8'h00

// timing: frame tick rate derived from the core clock
`define UHI_CLK_MHZ 20
`define UHI_FRAME_TICK_MHZ 12
`define UHI_FT_ACC_W 5
`define UHI_FT_W 14

`endif

// ===== hw/uhi_pkg.sv
// types for the host irq status logic
// assumes the map header supplies all numbers
package uhi_pkg;
    typedef logic [7:0] uhi_byte_t;
    typedef enum logic {
        LN_DETACHED,
        LN_ATTACHED
    } uhi_line_t;
endpackage

// ===== hw/uhi_frame_timer.sv
// frame timer: 12 MHz down counter, reload on zero, one-cycle expiry pulse
// assumes a 20 MHz clk; the 12 MHz rate is a fractional enable from an accumulator
`timescale 1ns/10ps
`include "uhi_map.svh"
module uhi_frame_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [`UHI_FT_W-1:0] loadValue,
    // result
    output logic expire
);
    logic [`UHI_FT_ACC_W-1:0] tickAcc_ff;
    logic [`UHI_FT_ACC_W-1:0] accSum;
    logic tick;
    logic [`UHI_FT_W-1:0] count_ff;

    // tick pulses average 12 of every 20 cycles, so jitter is one core cycle
    assign accSum = tickAcc_ff + `UHI_FT_ACC_W'(`UHI_FRAME_TICK_MHZ);
    assign tick = run && (accSum >= `UHI_CLK_MHZ);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickAcc_ff <= '0;
        end else if (!run) begin
            tickAcc_ff <= '0;
        end else if (tick) begin
            tickAcc_ff <= accSum - `UHI_FT_ACC_W'(`UHI_CLK_MHZ);
        end else begin
            tickAcc_ff <= accSum;
        end
    end

    // count down from the load value; stopped timer tracks the load value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (!run) begin
                count_ff <= loadValue;
            end else if (tick) begin
                if (count_ff == '0) begin
                    count_ff <= loadValue;
                    expire <= 1'b1;
                end else begin
                    count_ff <= count_ff - 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ft_reload: assert property (expire |-> count_ff == $past(loadValue))
        else $error("frame timer did not reload after expiry");
    a_ft_stopped: assert property (!run |=> !expire)
        else $error("frame timer expired while stopped");
endmodule

// ===== tb/uhi_cpu_model.sv
// host processor model: two-step byte port access, address phase then data phase
// assumes clk is the block clock; strobes move by nba at rising edges
`timescale 1ns/10ps
module uhi_cpu_model (
    // clock
    input wire logic clk,
    // processor port
    output logic csN,
    output logic rdN,
    output logic wrN,
    output logic a0,
    output logic [7:0] dataIn,
    input wire logic [7:0] dataOut
);
    // idle bus at time zero
    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        a0 = 1'b0;
        dataIn = 8'h00;
    end

    // one strobe cycle; strobe back high a full cycle before the next access
    task automatic cyc(input logic wr, input logic sel, input logic [7:0] d);
        @(posedge clk);
        csN <= 1'b0;
        a0 <= sel;
        dataIn <= d;
        if (wr) begin
            wrN <= 1'b0;
        end else begin
            rdN <= 1'b0;
        end
        @(posedge clk);
        csN <= 1'b1;
        wrN <= 1'b1;
        rdN <= 1'b1;
        dataIn <= ~d; // released data must not keep the last value
    endtask

    // pointer then data; offset 07h is never written in host mode
    task automatic reg_wr(input logic [7:0] off, input logic [7:0] v);
        cyc(1'b1, 1'b0, off);
        cyc(1'b1, 1'b1, v);
    endtask

    // read data lands at the edge that takes the strobe
    task automatic reg_rd(input logic [7:0] off, output logic [7:0] v);
        cyc(1'b1, 1'b0, off);
        cyc(1'b0, 1'b1, 8'h00);
        #1 v = dataOut;
    endtask
endmodule

// ===== tb/test_usb_host_irq_status_logic.sv
// self-checking bench for the host irq status logic
// assumes the processor model in uhi_cpu_model drives the byte port
`timescale 1ns/10ps
`include "uhi_map.svh"
module test_usb_host_irq_status_logic;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic dPlus = 1'b0, dMinus = 1'b0, suspendMode = 1'b0, sofEnable = 1'b0;
    logic chanDoneA = 1'b0, chanDoneB = 1'b0;
    logic [7:0] chanEventA = 8'h00, chanEventB = 8'h00;
    logic [13:0] frameLoad = 14'h0003;
    logic csN, rdN, wrN, a0, dataOe, irq_request_out, frameExpire;
    logic txPowerDown, ramSuspend, clockGateOff;
    logic [7:0] dataIn, dataOut, pktStatusA, pktStatusB;
    wire logic [7:0] irqV = {7'h00, irq_request_out};
    int err_count = 0, checked = 0, cycles = 0, nExp = 0;

    uhi_irq_status uhi_irq_status_inst (.clk(clk), .rst_n(rst_n), .csN(csN), .rdN(rdN), .wrN(wrN), .a0(a0),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .dPlus(dPlus), .dMinus(dMinus),
        .suspendMode(suspendMode), .sofEnable(sofEnable), .frameLoad(frameLoad), .chanDoneA(chanDoneA),
        .chanDoneB(chanDoneB), .chanEventA(chanEventA), .chanEventB(chanEventB), .pktStatusA(pktStatusA),
        .pktStatusB(pktStatusB), .irq_request_out(irq_request_out), .frameExpire(frameExpire),
        .txPowerDown(txPowerDown), .ramSuspend(ramSuspend), .clockGateOff(clockGateOff));
    uhi_cpu_model uhi_cpu_model_inst (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN), .a0(a0), .dataIn(dataIn),
        .dataOut(dataOut));

    // 20 MHz clock
    always #25 clk = ~clk;

    // timeout well above the expected run length, plus frame pulse counting
    always @(posedge clk) begin
        cycles++;
        if (frameExpire === 1'b1) begin
            nExp++;
        end
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic w(input logic [7:0] o, input logic [7:0] d);
        uhi_cpu_model_inst.reg_wr(o, d);
    endtask

    task automatic r(input logic [7:0] o, output logic [7:0] v);
        uhi_cpu_model_inst.reg_rd(o, v);
    endtask

    // let registered updates and the combinational request settle
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input logic ch, input logic [7:0] ev);
        @(posedge clk);
        chanEventA <= ev;
        chanEventB <= ev;
        chanDoneA <= ~ch;
        chanDoneB <= ch;
        @(posedge clk);
        chanDoneA <= 1'b0;
        chanDoneB <= 1'b0;
        settle();
    endtask

    // reset values, reserved enable bits, unmapped offset
    task automatic t_reset();
        logic [7:0] v;
        r(`UHI_REG_STATUS, v);
        chk("status reset", v, 8'h40);
        r(`UHI_REG_ENABLE, v);
        chk("enable reset", v, 8'h00);
        w(`UHI_REG_ENABLE, 8'hff);
        r(`UHI_REG_ENABLE, v);
        chk("enable mask", v, 8'h73);
        chk("irq no device", irqV, 8'h01);
        fork
            r(8'h20, v);
            begin
                repeat (3) @(posedge clk);
                #1 chk("oe in read", {7'h00, dataOe}, 8'h01);
            end
        join
        chk("unmapped", v, 8'h00);
        chk("oe after read", {7'h00, dataOe}, 8'h00);
        uhi_cpu_model_inst.cyc(1'b0, 1'b0, 8'h00);
        #1 chk("pointer read", dataOut, 8'h20);
        w(`UHI_REG_ENABLE, 8'h00);
        settle();
        chk("irq off", irqV, 8'h00);
        $display("test reset done");
    endtask

    // done flags of both channels, masked, enabled, partial clear
    task automatic t_done();
        logic [7:0] v, m;
        for (int ch = 0; ch < 2; ch++) begin
            m = 8'h01 << ch;
            pulse(ch[0], 8'ha5 ^ m);
            chk("pkt status", ch ? pktStatusB : pktStatusA, 8'ha5 ^ m);
            chk("irq masked", irqV, 8'h00);
            w(`UHI_REG_ENABLE, m);
            pulse(ch[0], 8'h5a ^ m);
            chk("pkt again", ch ? pktStatusB : pktStatusA, 8'h5a ^ m);
            chk("irq done", irqV, 8'h01);
            w(`UHI_REG_STATUS, 8'h0f & ~m);
            r(`UHI_REG_STATUS, v);
            chk("zero write keeps", v & 8'h0f, m);
            chk("irq level", irqV, 8'h01);
            w(`UHI_REG_STATUS, m);
            r(`UHI_REG_STATUS, v);
            chk("done clear", v & m, 8'h00);
            chk("irq cleared", irqV, 8'h00);
            w(`UHI_REG_ENABLE, 8'h00);
        end
        $display("test done flags done");
    endtask

    // clearing write and done events in one cycle: the events win
    task automatic t_race();
        logic [7:0] v;
        fork
            w(`UHI_REG_STATUS, 8'h03);
            begin
                repeat (3) @(posedge clk);
                chanDoneA <= 1'b1;
                chanDoneB <= 1'b1;
                @(posedge clk);
                chanDoneA <= 1'b0;
                chanDoneB <= 1'b0;
            end
        join
        r(`UHI_REG_STATUS, v);
        chk("set beats clear", v & 8'h03, 8'h03);
        w(`UHI_REG_STATUS, 8'h03);
        r(`UHI_REG_STATUS, v);
        chk("race cleared", v & 8'h03, 8'h00);
        $display("test race done");
    endtask

    // full and low speed attach, detach
    task automatic t_line();
        logic [7:0] v;
        @(posedge clk);
        dPlus <= 1'b1;
        r(`UHI_REG_STATUS, v);
        chk("attach full", v, 8'ha0);
        w(`UHI_REG_ENABLE, 8'h20);
        settle();
        chk("irq insert", irqV, 8'h01);
        w(`UHI_REG_STATUS, 8'h20);
        settle();
        chk("irq insert clr", irqV, 8'h00);
        @(posedge clk);
        dPlus <= 1'b0;
        r(`UHI_REG_STATUS, v);
        chk("detach", v, 8'h60);
        w(`UHI_REG_STATUS, 8'h20);
        @(posedge clk);
        dMinus <= 1'b1;
        r(`UHI_REG_STATUS, v);
        chk("attach low", v, 8'h20);
        @(posedge clk);
        dMinus <= 1'b0;
        w(`UHI_REG_STATUS, 8'h20);
        w(`UHI_REG_ENABLE, 8'h00);
        $display("test line done");
    endtask

    // suspend outputs and the resume flag sharing bit 6
    task automatic t_suspend();
        logic [7:0] v;
        @(posedge clk);
        suspendMode <= 1'b1;
        w(`UHI_REG_ENABLE, 8'h40);
        settle();
        chk("power down", {5'h00, txPowerDown, ramSuspend, clockGateOff}, 8'h07);
        chk("irq no resume", irqV, 8'h00);
        @(posedge clk);
        dMinus <= 1'b1; // one cycle of k state on the bus
        @(posedge clk);
        dMinus <= 1'b0;
        r(`UHI_REG_STATUS, v);
        chk("resume flag", v & 8'h40, 8'h40);
        chk("irq resume", irqV, 8'h01);
        w(`UHI_REG_STATUS, 8'h60);
        r(`UHI_REG_STATUS, v);
        chk("resume clear", v & 8'h40, 8'h00);
        chk("irq resume clr", irqV, 8'h00);
        w(`UHI_REG_ENABLE, 8'h00);
        @(posedge clk);
        suspendMode <= 1'b0;
        $display("test suspend done");
    endtask

    // frame timer: load 3 gives 4 ticks at 12 of every 20 clocks
    task automatic t_frame();
        logic [7:0] v;
        w(`UHI_REG_ENABLE, 8'h10);
        nExp = 0;
        @(posedge clk);
        sofEnable <= 1'b1; // load value set before relying on the tick
        repeat (200) @(posedge clk);
        sofEnable <= 1'b0;
        settle();
        chk("frame rate", (nExp >= 29 && nExp <= 31) ? 8'h01 : 8'h00, 8'h01);
        r(`UHI_REG_STATUS, v);
        chk("frame flag", v & 8'h10, 8'h10);
        chk("irq frame", irqV, 8'h01);
        w(`UHI_REG_STATUS, 8'h10);
        r(`UHI_REG_STATUS, v);
        chk("frame clear", v & 8'h10, 8'h00);
        $display("test frame done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_done();
        t_race();
        t_line();
        t_suspend();
        t_frame();
        conclude();
    end
endmodule
